// ---- ipgo_board.sv ----
// board model for the two serial pads
// assumes pull-ups and no other driver
`timescale 1ns/1ps
`default_nettype none
module ipgo_board (
	input wire logic scl_o,
	input wire logic scl_oe,
	input wire logic sda_o,
	input wire logic sda_oe,
	output logic scl_i,
	output logic sda_i
);
	// a released pad floats up through its pull-up
	assign scl_i = scl_oe ? scl_o : 1'b1;
	assign sda_i = sda_oe ? sda_o : 1'b1;
endmodule : ipgo_board
`default_nettype wire

// ---- ipgo_checker.sv ----
// port checker for ipgo_top
// assumes controller-mode pads only ever drive low
`timescale 1ns/1ps
`default_nettype none
module ipgo_checker import ipgo_pkg::*; (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [IPGO_AW-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	input wire logic scl_o,
	input wire logic scl_oe,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic ctl_scl_oe,
	input wire logic ctl_sda_oe,
	input wire logic ctl_scl_in,
	input wire logic ctl_sda_in
);
	// oe with no controller request can only be a gpio drive
	wire logic g_d = sda_oe && !ctl_sda_oe;
	wire logic g_c = scl_oe && !ctl_scl_oe;
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	sequence wr_at(logic [7:0] a); reg_wr && reg_addr == a; endsequence
	out_data_a: assert property (wr_at(IPGO_OFF_OUT) |=> !g_d || sda_o == $past(reg_wdata[1]))
		else $error("data pad");
	out_clk_a: assert property (wr_at(IPGO_OFF_OUT) |=> !g_c || scl_o == $past(reg_wdata[0]))
		else $error("clock pad");
	set_bit_a: assert property (wr_at(IPGO_OFF_SET) ##0 reg_wdata[1] |=> !g_d || sda_o)
		else $error("set");
	clr_bit_a: assert property (wr_at(IPGO_OFF_CLR) ##0 reg_wdata[0] |=> !g_c || !scl_o)
		else $error("clear");
	no_drive_a: assert property (wr_at(IPGO_OFF_OUT) ##0 !g_d |=> !g_d)
		else $error("input driven");
	dir_off_a: assert property (wr_at(IPGO_OFF_DIR) ##0 !reg_wdata[1] |=> !g_d)
		else $error("direction");
	ctl_high_a: assert property (g_d || g_c |-> ctl_sda_in && ctl_scl_in)
		else $error("controller input");
	upper_zero_a: assert property (reg_rd |=> reg_rdata[31:2] == 0)
		else $error("upper bits");
endmodule : ipgo_checker
bind ipgo_top ipgo_checker i_chk(.*);
`default_nettype wire

// ---- ipgo_pin.sv ----
// one open pad: mux between serial controller and gpio driver
// assumes the pad resolves level from oe
`timescale 1ns/1ps
`default_nettype none
module ipgo_pin
	import ipgo_pkg::*;
(
	input wire logic gpio_mode,
	input wire logic dir_out,
	input wire logic out_val,
	input wire logic ctl_oe,
	input wire logic pin_sync,
	output logic pin_o,
	output logic pin_oe,
	output logic ctl_in
);
	always_comb begin
		if (gpio_mode) begin
			pin_oe = dir_out; // [R11] [R1] [R2]
			pin_o = out_val; // [R9]
			ctl_in = 1'b1; // [R12]
		end else begin
			// controller only pulls low; high is released
			pin_oe = ctl_oe;
			pin_o = 1'b0;
			ctl_in = pin_sync;
		end
	end
endmodule : ipgo_pin
`default_nettype wire

// ---- ipgo_pkg.sv ----
// package for the serial-pin gpio output block: offsets, field positions, reset values
// assumes a plain register port with 32-bit data and byte addresses
//
// Overview of operation
// R1: a pin set as a gpio output is driven with the level of its output value bit.
// R2: writing the output value never changes a pin that is not a gpio output.
// R3: reading the output value returns the stored bits, never the pin levels.
// R4: a direct write to the output value loads both bits at once.
// R5: a one written to the set alias sets that output bit, a zero leaves it alone.
// R6: a one written to the clear alias clears that output bit, a zero leaves it alone.
// R7: software ignores whatever the set and clear aliases return when read.
// R8: upper bits of the three registers read as zero and ignore writes.
// R9: bit 1 is the data line and bit 0 the clock line; 0 drives low and 1 drives high.
// R10: software sets gpio select before expecting the output bits to reach the pins.
// R11: a direction bit of one makes its pin an output, zero an input, only in gpio mode.
// R12: in gpio mode the serial controller sees a constant high on clock and data.
// R13: software holds the serial controller in reset while changing gpio mode.
// R14: module reset clears both output value bits.
package ipgo_pkg;
	localparam int IPGO_AW = 8;
	localparam logic [7:0] IPGO_OFF_FUNC = 8'h4c;
	localparam logic [7:0] IPGO_OFF_DIR = 8'h50;
	localparam logic [7:0] IPGO_OFF_DIN = 8'h54;
	localparam logic [7:0] IPGO_OFF_SET = 8'h58;
	localparam logic [7:0] IPGO_OFF_CLR = 8'h5c;
	localparam logic [7:0] IPGO_OFF_OUT = 8'h60;
	localparam int IPGO_BIT_CLK = 0;
	localparam int IPGO_BIT_DAT = 1;
	localparam int IPGO_BIT_GPIO_SEL = 0;
	localparam logic [1:0] IPGO_OUT_RST = 2'h0;
	localparam logic [1:0] IPGO_DIR_RST = 2'h0;
	localparam logic IPGO_FUNC_RST = 1'b0;
endpackage : ipgo_pkg

// ---- ipgo_sync2.sv ----
// two-flop synchroniser for one pin level
// assumes the input is asynchronous to core_clk
`timescale 1ns/1ps
`default_nettype none
module ipgo_sync2
	import ipgo_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic async_in,
	output logic sync_out
);
	typedef struct packed {
		logic s1;
		logic s2;
	} ipgo_sync_t;
	ipgo_sync_t st, next_st;
	always_comb begin
		next_st.s1 = async_in;
		next_st.s2 = st.s1;
	end
	// idle bus is high, so reset to one
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= 2'b11;
		end else begin
			st <= next_st;
		end
	end
	assign sync_out = st.s2;
endmodule : ipgo_sync2
`default_nettype wire

// ---- ipgo_tb_top.sv ----
// bench for ipgo_top against an integer model
// assumes ipgo_board on the pads
`timescale 1ns/1ps
`default_nettype none
module ipgo_tb_top import ipgo_pkg::*; ;
	logic core_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, ctl_scl_oe = 0, ctl_sda_oe = 0;
	logic [7:0] reg_addr = 0;
	logic [31:0] reg_wdata = 0, reg_rdata, d;
	logic scl_i, scl_o, scl_oe, sda_i, sda_o, sda_oe, ctl_scl_in, ctl_sda_in;
	logic [7:0] ofs [3] = '{IPGO_OFF_OUT, IPGO_OFF_SET, IPGO_OFF_CLR};
	int n_errors = 0, n_tests = 0, m = 0;
	ipgo_top i_dut(.*);
	ipgo_board i_board(.*);
	initial forever #10 core_clk = ~core_clk;
	task chk(string n, logic [31:0] e, s);
		n_tests++;
		if (e !== s) begin
			n_errors++;
			$display("ERROR %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task bus(logic w, logic [7:0] a, logic [31:0] v);
		@(posedge core_clk);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge core_clk);
		reg_wr <= 0;
		reg_rd <= 0;
		#1;
	endtask : bus
	task close_out;
		if (n_errors == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : close_out
	initial begin
		void'($urandom(53));
		repeat (5) @(posedge core_clk);
		sys_rst <= 0;
		bus(0, IPGO_OFF_OUT, 0);
		chk("reset", 0, reg_rdata);
		bus(1, IPGO_OFF_FUNC, 1); // controller request lines idle across the switch
		bus(1, IPGO_OFF_DIR, 3);
		for (int i = 0; i < 30; i++) begin
			d = $urandom;
			ctl_sda_oe <= d[7];
			m = i % 3 == 0 ? d : i % 3 == 1 ? m | d : m & ~d;
			bus(1, ofs[i % 3], d);
			chk("pads", {1'b1, m[1], 1'b1, m[0]}, {sda_oe, sda_o, scl_oe, scl_o});
			bus(0, ofs[0], 0);
			chk("out", m & 3, reg_rdata);
		end
		ctl_sda_oe <= 0; // controller goes quiet before the next mode change
		bus(0, IPGO_OFF_SET, 0); // alias read data is never relied on
		bus(1, IPGO_OFF_DIR, 1);
		bus(1, IPGO_OFF_OUT, 32'hffff_fffc);
		chk("released", 3'b010, {sda_oe, scl_oe, scl_o});
		bus(0, IPGO_OFF_OUT, 0);
		chk("stored", 0, reg_rdata);
		bus(0, 8'hf0, 0);
		chk("unmapped", 0, reg_rdata);
		// clock pin is driven low here, so a constant high proves the substitution
		chk("ctl in gpio", 2'h3, {ctl_sda_in, ctl_scl_in});
		bus(1, IPGO_OFF_FUNC, 0);
		ctl_sda_oe <= 1;
		bus(1, IPGO_OFF_OUT, 3);
		chk("ctl mode", 6'h21, {sda_oe, sda_o, scl_oe, scl_o, ctl_sda_in, ctl_scl_in});
		bus(0, IPGO_OFF_DIN, 0);
		chk("pins", 1, reg_rdata);
		bus(0, IPGO_OFF_OUT, 0);
		chk("stored high", 3, reg_rdata);
		@(posedge core_clk);
		sys_rst <= 1;
		repeat (3) @(posedge core_clk);
		sys_rst <= 0;
		bus(0, IPGO_OFF_OUT, 0);
		chk("reset again", 0, reg_rdata);
		close_out();
	end
endmodule : ipgo_tb_top
`default_nettype wire

// ---- ipgo_top.sv ----
// register port and gpio output path for the two serial pins
// assumes single-cycle strobes, read data one cycle after read strobe
`timescale 1ns/1ps
`default_nettype none
module ipgo_top
	import ipgo_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [IPGO_AW-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic ctl_scl_oe,
	input wire logic ctl_sda_oe,
	output logic ctl_scl_in,
	output logic ctl_sda_in,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe
);
	typedef struct packed {
		logic [1:0] pin_output_value;
		logic [1:0] pin_direction_register;
		logic pin_gpio_select;
		logic [31:0] rdata;
	} ipgo_state_t;
	ipgo_state_t st, next_st;
	logic scl_s, sda_s;
	logic [1:0] pin_in;

	ipgo_sync2 u_sync_scl (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.async_in(scl_i),
		.sync_out(scl_s)
	);
	ipgo_sync2 u_sync_sda (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.async_in(sda_i),
		.sync_out(sda_s)
	);
	assign pin_in = {sda_s, scl_s};

	always_comb begin
		next_st = st;
		next_st.rdata = 32'h0000_0000;
		if (reg_wr) begin
			case (reg_addr)
				IPGO_OFF_FUNC: next_st.pin_gpio_select = reg_wdata[IPGO_BIT_GPIO_SEL];
				IPGO_OFF_DIR: next_st.pin_direction_register = reg_wdata[1:0];
				// upper write bits are dropped [R8]
				IPGO_OFF_OUT: next_st.pin_output_value = reg_wdata[1:0]; // [R4]
				IPGO_OFF_SET: next_st.pin_output_value = st.pin_output_value | reg_wdata[1:0]; // [R5]
				IPGO_OFF_CLR: next_st.pin_output_value = st.pin_output_value & ~reg_wdata[1:0]; // [R6]
				default: ;
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				IPGO_OFF_FUNC: next_st.rdata = {31'h0, st.pin_gpio_select};
				IPGO_OFF_DIR: next_st.rdata = {30'h0, st.pin_direction_register};
				IPGO_OFF_DIN: next_st.rdata = {30'h0, pin_in};
				// stored bits, not pins [R3] [R8]
				IPGO_OFF_OUT: next_st.rdata = {30'h0, st.pin_output_value};
				// aliases read zero; software must not rely on it [R7]
				default: next_st.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st.pin_output_value <= IPGO_OUT_RST; // [R14]
			st.pin_direction_register <= IPGO_DIR_RST;
			st.pin_gpio_select <= IPGO_FUNC_RST;
			st.rdata <= 32'h0000_0000;
		end else begin
			st <= next_st;
		end
	end
	assign reg_rdata = st.rdata;

	// controller reset during mode change is software's duty [R13] [R10]
	ipgo_pin u_pin_scl (
		.gpio_mode(st.pin_gpio_select),
		.dir_out(st.pin_direction_register[IPGO_BIT_CLK]),
		.out_val(st.pin_output_value[IPGO_BIT_CLK]),
		.ctl_oe(ctl_scl_oe),
		.pin_sync(scl_s),
		.pin_o(scl_o),
		.pin_oe(scl_oe),
		.ctl_in(ctl_scl_in)
	);
	ipgo_pin u_pin_sda (
		.gpio_mode(st.pin_gpio_select),
		.dir_out(st.pin_direction_register[IPGO_BIT_DAT]),
		.out_val(st.pin_output_value[IPGO_BIT_DAT]),
		.ctl_oe(ctl_sda_oe),
		.pin_sync(sda_s),
		.pin_o(sda_o),
		.pin_oe(sda_oe),
		.ctl_in(ctl_sda_in)
	);
endmodule : ipgo_top
`default_nettype wire
